//--- include/mem_ref_pkg.sv
// Contract
// (RULE1) Pre-offset only: the address is the base register plus the sign-extended displacement.
// (RULE2) Pre-offset with indirect: the word at base plus displacement becomes the address.
// (RULE3) Post-index only: the address is the index register plus the displacement.
// (RULE4) Post-index with pre-offset: index plus base plus displacement, with no indirect fetch.
// (RULE5) Post-index with indirect: the word at program counter plus displacement, plus the index.
// (RULE6) All three flags: as RULE5, but the pointer sits at base plus displacement.
// (RULE7) The clear op writes a zero word and changes no register.
// (RULE8) The single-register ops write the accumulator, T or index register.
// (RULE9) Storing the index register in an indexed mode uses and stores that same value.
// (RULE10) The double-word op writes the accumulator at the target and D at target plus one.
// (RULE11) The float op writes three words from the target, exponent word first.
// (RULE12) Increment op reads, adds one, writes back, and skips the next instruction on zero.
// (RULE13) Opcode in bits 15-11, post-index 10, indirect 9, pre-offset 8, displacement 7-0.
// (RULE14) Base offset comes before the indirect fetch, index after; indirect costs one cycle.
// (RULE15) No flags set: the address is the program counter plus the displacement.
// (RULE16) All address sums and plus-one/plus-two offsets wrap modulo 65536.
package mem_ref_pkg;
	localparam logic [4:0] OP_CLEAR = 5'h00;
	localparam logic [4:0] OP_ACCUM = 5'h01;
	localparam logic [4:0] OP_TREG = 5'h02;
	localparam logic [4:0] OP_INDEX = 5'h03;
	localparam logic [4:0] OP_DOUBLE = 5'h04;
	localparam logic [4:0] OP_FLOAT = 5'h06;
	localparam logic [4:0] OP_INCR = 5'h08;
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 11;
	localparam int POSTX_BIT = 10;
	localparam int INDIR_BIT = 9;
	localparam int PREB_BIT = 8;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] WORD_ONE = 16'h0001;
	localparam logic [15:0] WORD_TWO = 16'h0002;

	typedef struct packed {
		logic [4:0] opcode;
		logic postIndex;
		logic indirect;
		logic preOffset;
		logic [7:0] disp;
	} instr_t;

	typedef struct packed {
		logic [15:0] progCount;
		logic [15:0] baseReg;
		logic [15:0] indexReg;
		logic [15:0] accum;
		logic [15:0] tReg;
		logic [15:0] dReg;
	} regs_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;
endpackage

//--- rtl/ea_adder.sv
`timescale 1ns/100ps
`default_nettype none
module ea_adder
(
	input wire logic [15:0] baseVal,
	input wire logic [7:0] disp,
	input wire logic [15:0] addVal,
	input wire logic addEn,
	output logic [15:0] sum
);
	// RULE16 wrap mod 65536
	always_comb
	begin
		sum = baseVal + {{8{disp[7]}}, disp} + (addEn ? addVal : mem_ref_pkg::WORD_ZERO);
	end
endmodule // ea_adder
`default_nettype wire

//--- rtl/op_decode.sv
`timescale 1ns/100ps
`default_nettype none
module op_decode
(
	input wire logic [15:0] instrWord,
	output mem_ref_pkg::instr_t fields,
	output logic known
);
	// RULE13 field split
	always_comb
	begin
		fields = mem_ref_pkg::instr_t'(instrWord);
		case (instrWord[mem_ref_pkg::OPC_HI:mem_ref_pkg::OPC_LO])
			mem_ref_pkg::OP_CLEAR, mem_ref_pkg::OP_ACCUM, mem_ref_pkg::OP_TREG,
			mem_ref_pkg::OP_INDEX, mem_ref_pkg::OP_DOUBLE, mem_ref_pkg::OP_FLOAT,
			mem_ref_pkg::OP_INCR: known = 1'b1;
			default: known = 1'b0;
		endcase
	end
endmodule // op_decode
`default_nettype wire

//--- rtl/mem_ref_address_and_store.sv
`timescale 1ns/100ps
`default_nettype none
module mem_ref_address_and_store
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [15:0] instrWord,
	input wire mem_ref_pkg::regs_t regs,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	output mem_ref_pkg::mem_req_t memReq,
	output logic done,
	output logic skip,
	output logic [15:0] nextPc,
	output logic badOp,
	output logic busy
);
	typedef enum {IDLE, PTR_RD, OPND_RD, WR0, WR1, WR2, FINISH} state_t;

	state_t state_reg, state_next;
	mem_ref_pkg::instr_t ins_reg, ins_next;
	mem_ref_pkg::regs_t regs_reg, regs_next;
	mem_ref_pkg::mem_req_t memReq_reg, memReq_next;
	logic [15:0] target_word_reg, target_word_next;
	logic [15:0] incr_reg, incr_next;
	logic done_reg, done_next;
	logic skip_reg, skip_next;
	logic [15:0] nextPc_reg, nextPc_next;
	logic badOp_reg, badOp_next;
	logic busy_reg, busy_next;

	mem_ref_pkg::instr_t decFields;
	logic decKnown;
	logic [15:0] ptrBase;
	logic [15:0] directAddr;
	logic [15:0] ptrAddr;
	logic [15:0] sumD;
	logic [15:0] sumP;

	op_decode u_dec
	(
		.instrWord(instrWord),
		.fields(decFields),
		.known(decKnown)
	);

	// B replaces P as the base whenever the pre-offset flag is set
	function automatic logic [15:0] relBase(input mem_ref_pkg::instr_t f,
		input mem_ref_pkg::regs_t r);
		relBase = f.preOffset ? r.baseReg : r.progCount;
	endfunction

	// RULE15 P, B or zero base
	always_comb
	begin
		ptrBase = relBase(decFields, regs);
		if (decFields.postIndex && !decFields.preOffset)
			ptrBase = mem_ref_pkg::WORD_ZERO;
	end

	// RULE1 RULE3 RULE4 direct sum
	ea_adder u_direct
	(
		.baseVal(ptrBase),
		.disp(decFields.disp),
		.addVal(regs.indexReg),
		.addEn(decFields.postIndex),
		.sum(sumD)
	);

	// The pointer location never includes X; post-index is added after the fetch
	// RULE14 pre-offset before fetch
	ea_adder u_ptr
	(
		.baseVal(relBase(decFields, regs)),
		.disp(decFields.disp),
		.addVal(mem_ref_pkg::WORD_ZERO),
		.addEn(1'b0),
		.sum(sumP)
	);

	always_comb
	begin
		directAddr = sumD;
		ptrAddr = sumP;
	end

	function automatic logic [15:0] opData(input logic [4:0] op, input mem_ref_pkg::regs_t r);
		case (op)
			mem_ref_pkg::OP_ACCUM: opData = r.accum;
			mem_ref_pkg::OP_TREG: opData = r.tReg;
			mem_ref_pkg::OP_INDEX: opData = r.indexReg;
			mem_ref_pkg::OP_DOUBLE: opData = r.accum;
			mem_ref_pkg::OP_FLOAT: opData = r.tReg;
			default: opData = mem_ref_pkg::WORD_ZERO;
		endcase
	endfunction

	// Op classes that change the state sequence
	function automatic logic isIncr(input logic [4:0] op);
		isIncr = (op == mem_ref_pkg::OP_INCR);
	endfunction

	function automatic logic multiWord(input logic [4:0] op);
		multiWord = (op == mem_ref_pkg::OP_DOUBLE) || (op == mem_ref_pkg::OP_FLOAT);
	endfunction

	// Word n of a store: float puts the exponent (T) first, then A, then D
	function automatic logic [15:0] wordData(input logic [1:0] idx, input logic [4:0] op,
		input mem_ref_pkg::regs_t r);
		case (idx)
			2'h0: wordData = opData(op, r);
			2'h1: wordData = (op == mem_ref_pkg::OP_DOUBLE) ? r.dReg : r.accum;
			default: wordData = r.dReg;
		endcase
	endfunction

	always_comb
	begin
		state_next = state_reg;
		ins_next = ins_reg;
		regs_next = regs_reg;
		memReq_next = memReq_reg;
		target_word_next = target_word_reg;
		incr_next = incr_reg;
		done_next = 1'b0;
		skip_next = skip_reg;
		nextPc_next = nextPc_reg;
		badOp_next = badOp_reg;
		case (state_reg)
			IDLE:
			begin
				if (start)
				begin
					// Registers are copied here so the caller may change them at once
					ins_next = decFields;
					regs_next = regs;
					skip_next = 1'b0;
					badOp_next = !decKnown;
					nextPc_next = regs.progCount + mem_ref_pkg::WORD_ONE;
					memReq_next.req = 1'b0;
					if (!decKnown)
					begin
						state_next = FINISH;
					end
					else if (decFields.indirect)
					begin
						// RULE2 RULE5 RULE6 pointer fetch
						memReq_next.req = 1'b1;
						memReq_next.write = 1'b0;
						memReq_next.addr = ptrAddr;
						state_next = PTR_RD;
					end
					else
					begin
						target_word_next = directAddr;
						state_next = OPND_RD;
					end
				end
			end
			PTR_RD:
			begin
				if (memAck)
				begin
					memReq_next.req = 1'b0;
					// RULE14 index after fetch
					target_word_next = memRdata
						+ (ins_reg.postIndex ? regs_reg.indexReg : mem_ref_pkg::WORD_ZERO);
					state_next = OPND_RD;
				end
			end
			OPND_RD:
			begin
				if (isIncr(ins_reg.opcode))
				begin
					// RULE12 read then write
					if (!memReq_reg.req)
					begin
						memReq_next.req = 1'b1;
						memReq_next.write = 1'b0;
						memReq_next.addr = target_word_reg;
					end
					else if (memAck)
					begin
						memReq_next.req = 1'b0;
						incr_next = memRdata + mem_ref_pkg::WORD_ONE;
						state_next = WR0;
					end
				end
				else
				begin
					state_next = WR0;
				end
			end
			WR0:
			begin
				if (!memReq_reg.req)
				begin
					// RULE7 RULE8 RULE9 RULE10 first word
					memReq_next.req = 1'b1;
					memReq_next.write = 1'b1;
					memReq_next.addr = target_word_reg;
					memReq_next.wdata = isIncr(ins_reg.opcode)
						? incr_reg : wordData(2'h0, ins_reg.opcode, regs_reg);
				end
				else if (memAck)
				begin
					memReq_next.req = 1'b0;
					if (multiWord(ins_reg.opcode))
						state_next = WR1;
					else
						state_next = FINISH;
					// The write-back has already landed when the skip is taken
					// RULE12 skip on zero
					if (isIncr(ins_reg.opcode) && incr_reg == mem_ref_pkg::WORD_ZERO)
					begin
						skip_next = 1'b1;
						nextPc_next = regs_reg.progCount + mem_ref_pkg::WORD_TWO;
					end
				end
			end
			WR1:
			begin
				if (!memReq_reg.req)
				begin
					// RULE10 RULE11 second word
					memReq_next.req = 1'b1;
					memReq_next.write = 1'b1;
					memReq_next.addr = target_word_reg + mem_ref_pkg::WORD_ONE;
					memReq_next.wdata = wordData(2'h1, ins_reg.opcode, regs_reg);
				end
				else if (memAck)
				begin
					memReq_next.req = 1'b0;
					state_next = (ins_reg.opcode == mem_ref_pkg::OP_FLOAT) ? WR2 : FINISH;
				end
			end
			WR2:
			begin
				if (!memReq_reg.req)
				begin
					// RULE11 RULE16 third word wraps
					memReq_next.req = 1'b1;
					memReq_next.write = 1'b1;
					memReq_next.addr = target_word_reg + mem_ref_pkg::WORD_TWO;
					memReq_next.wdata = wordData(2'h2, ins_reg.opcode, regs_reg);
				end
				else if (memAck)
				begin
					memReq_next.req = 1'b0;
					state_next = FINISH;
				end
			end
			FINISH:
			begin
				// Unknown opcodes come straight here, so they never start a memory cycle
				done_next = 1'b1;
				state_next = IDLE;
			end
			default: state_next = IDLE;
		endcase
		// Busy follows the next state, so it is high from the edge that takes start
		busy_next = (state_next != IDLE);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= IDLE;
			ins_reg <= '0;
			regs_reg <= '0;
			memReq_reg <= '0;
			target_word_reg <= mem_ref_pkg::WORD_ZERO;
			incr_reg <= mem_ref_pkg::WORD_ZERO;
			done_reg <= 1'b0;
			skip_reg <= 1'b0;
			nextPc_reg <= mem_ref_pkg::WORD_ZERO;
			badOp_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ins_reg <= ins_next;
			regs_reg <= regs_next;
			memReq_reg <= memReq_next;
			target_word_reg <= target_word_next;
			incr_reg <= incr_next;
			done_reg <= done_next;
			skip_reg <= skip_next;
			nextPc_reg <= nextPc_next;
			badOp_reg <= badOp_next;
			busy_reg <= busy_next;
		end
	end

	assign memReq = memReq_reg;
	assign done = done_reg;
	assign skip = skip_reg;
	assign nextPc = nextPc_reg;
	assign badOp = badOp_reg;
	assign busy = busy_reg;
endmodule // mem_ref_address_and_store
`default_nettype wire

//--- tb/mem_ref_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mem_ref_sva
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [15:0] instrWord,
	input wire mem_ref_pkg::regs_t regs,
	input wire logic memAck,
	input wire mem_ref_pkg::mem_req_t memReq,
	input wire logic done,
	input wire logic skip,
	input wire logic [15:0] nextPc,
	input wire logic badOp,
	input wire logic busy
);
	logic [4:0] opReg;
	logic [15:0] pcReg;
	logic [15:0] lastAddr;
	logic [1:0] wrCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence launch;
		start && !busy && !done;
	endsequence
	sequence wrAck;
		memReq.req && memReq.write && memAck;
	endsequence
	// Shadow of the accepted instruction, so outputs can be tied to it
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			opReg <= 5'h00;
			pcReg <= 16'h0000;
			lastAddr <= 16'h0000;
			wrCnt <= 2'h0;
		end
		else if (start && !busy && !done)
		begin
			opReg <= instrWord[15:11];
			pcReg <= regs.progCount;
			wrCnt <= 2'h0;
		end
		else if (memReq.req && memReq.write && memAck)
		begin
			lastAddr <= memReq.addr;
			wrCnt <= wrCnt + 2'h1;
		end
	chk_req_hold: assert property (memReq.req && !memAck |=> memReq.req && $stable(memReq.addr))
		else $error("request changed before ack");
	chk_req_drop: assert property (memReq.req && memAck |=> !memReq.req)
		else $error("request held after ack");
	chk_bad_done: assert property (launch ##0 instrWord[15:11] == 5'h1F |-> ##[1:3] (done && badOp))
		else $error("bad opcode not reported");
	chk_bad_quiet: assert property (badOp |-> !memReq.req)
		else $error("memory access on bad opcode");
	chk_clear_zero: assert property (opReg == 5'h00 && memReq.req && memReq.write |-> memReq.wdata == 16'h0000)
		else $error("clear wrote nonzero");
	chk_pc_step: assert property (done |-> nextPc == pcReg + (skip ? 16'h0002 : 16'h0001))
		else $error("next pc wrong");
	chk_skip_incr: assert property (done && skip |-> opReg == 5'h08)
		else $error("skip outside increment");
	chk_word_step: assert property ($rose(memReq.req) && memReq.write && wrCnt != 2'h0 |-> memReq.addr == lastAddr + 16'h0001)
		else $error("multiword address step wrong");
	chk_busy_rise: assert property (launch |=> ##[0:1] busy)
		else $error("busy not raised");
	chk_write_after: assert property (wrAck |=> ##[1:4] (memReq.req || done))
		else $error("store sequence stalled");
endmodule // mem_ref_sva
bind mem_ref_address_and_store mem_ref_sva chk (.clk, .rstn, .start, .instrWord, .regs, .memAck,
	.memReq, .done, .skip, .nextPc, .badOp, .busy);
`default_nettype wire

//--- tb/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model
(
	input wire logic clk,
	input wire mem_ref_pkg::mem_req_t memReq,
	input wire logic [1:0] lat,
	output logic memAck,
	output logic [15:0] memRdata
);
	logic [15:0] mem [0:65535];
	logic [1:0] cnt = 2'h0;
	logic ackQ = 1'b0;
	logic [15:0] rdQ = 16'h0000;
	assign memAck = ackQ;
	assign memRdata = rdQ;
	// Read data only means something with the ack; toggle it otherwise
	always @(posedge clk)
	begin
		ackQ <= 1'b0;
		rdQ <= ~rdQ;
		if (memReq.req && !ackQ)
		begin
			if (cnt >= lat)
			begin
				ackQ <= 1'b1;
				cnt <= 2'h0;
				if (memReq.write)
					mem[memReq.addr] <= memReq.wdata;
				else
					rdQ <= mem[memReq.addr];
			end
			else
				cnt <= cnt + 2'h1;
		end
	end
endmodule // mem_model
`default_nettype wire

//--- tb/mem_ref_address_and_store_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin nTests++; if ((g) !== (e)) begin failCount++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module mem_ref_address_and_store_test;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	mem_ref_pkg::regs_t rg = '0;
	logic [1:0] lat = 2'h0;
	logic memAck;
	logic done;
	logic skip;
	logic badOp;
	logic busy;
	logic [15:0] memRdata;
	logic [15:0] nextPc;
	mem_ref_pkg::mem_req_t memReq;
	int failCount = 0;
	int nTests = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	mem_ref_address_and_store uut (.clk(clk), .rstn(rstn), .start(start), .instrWord(instrWord),
		.regs(rg), .memAck(memAck), .memRdata(memRdata), .memReq(memReq), .done(done),
		.skip(skip), .nextPc(nextPc), .badOp(badOp), .busy(busy));
	mem_model mm (.clk(clk), .memReq(memReq), .lat(lat), .memAck(memAck), .memRdata(memRdata));
	task printVerdict;
		$display("checks %0d errors %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic run(input logic [15:0] iw);
		int n;
		n = 0;
		@(posedge clk);
		#1 instrWord = iw;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		`CHK("busy", 1'b1, busy)
		while (done !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			#1 n++;
		end
		`CHK("done", 1'b1, done)
		`CHK("idle", 1'b0, busy)
	endtask
	function automatic logic [15:0] ea(input logic [2:0] m, input logic [7:0] d8);
		logic [15:0] a;
		a = (m[0] ? rg.baseReg : rg.progCount) + {{8{d8[7]}}, d8};
		if (m == 3'h4)
			a = rg.indexReg + {{8{d8[7]}}, d8};
		if (m[1])
			a = mm.mem[a];
		if (m[2] && m != 3'h4)
			a = a + rg.indexReg;
		return a;
	endfunction
	task automatic testModes;
		logic [15:0] e;
		rg = '{16'h0403, 16'h1000, 16'h0020, 16'h0000, 16'h0000, 16'h0000};
		for (int m = 0; m < 8; m++)
		begin
			lat = m[1:0];
			rg.accum = 16'hA500 + 16'(m);
			mm.mem[16'h03FF] = 16'h2000;
			mm.mem[16'h0FFC] = 16'h3000;
			e = ea(3'(m), 8'hFC);
			mm.mem[e] = 16'h0000;
			run({mem_ref_pkg::OP_ACCUM, 3'(m), 8'hFC});
			`CHK("mode ea", rg.accum, mm.mem[e])
		end
	endtask
	task automatic testOps;
		rg = '{16'h0100, 16'h0200, 16'hFFFE, 16'h1111, 16'h2222, 16'h3333};
		mm.mem[16'h0210] = 16'h1234;
		run({mem_ref_pkg::OP_CLEAR, 3'h1, 8'h10});
		`CHK("clear", 16'h0000, mm.mem[16'h0210])
		`CHK("clear pc", 16'h0101, nextPc)
		run({mem_ref_pkg::OP_TREG, 3'h0, 8'h10});
		`CHK("treg", 16'h2222, mm.mem[16'h0110])
		run({mem_ref_pkg::OP_INDEX, 3'h4, 8'h01});
		`CHK("index", 16'hFFFE, mm.mem[16'hFFFF])
		run({mem_ref_pkg::OP_DOUBLE, 3'h0, 8'h20});
		`CHK("dbl lo", 16'h1111, mm.mem[16'h0120])
		`CHK("dbl hi", 16'h3333, mm.mem[16'h0121])
		run({mem_ref_pkg::OP_FLOAT, 3'h4, 8'h01});
		`CHK("flt exp", 16'h2222, mm.mem[16'hFFFF])
		`CHK("flt mid", 16'h1111, mm.mem[16'h0000])
		`CHK("flt lo", 16'h3333, mm.mem[16'h0001])
		run({5'h1F, 3'h0, 8'h10});
		`CHK("bad", 1'b1, badOp)
		`CHK("bad mem", 16'h2222, mm.mem[16'h0110])
	endtask
	task automatic testIncr;
		rg = '{16'h0500, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		lat = 2'h2;
		mm.mem[16'h0505] = 16'hFFFF;
		run({mem_ref_pkg::OP_INCR, 3'h0, 8'h05});
		`CHK("inc wrap", 16'h0000, mm.mem[16'h0505])
		`CHK("skip", 1'b1, skip)
		`CHK("pc skip", 16'h0502, nextPc)
		run({mem_ref_pkg::OP_INCR, 3'h0, 8'h05});
		`CHK("inc", 16'h0001, mm.mem[16'h0505])
		`CHK("pc", 16'h0501, nextPc)
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		#1 rstn = 1'b1;
		testModes();
		testOps();
		testIncr();
		printVerdict();
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failCount++;
			printVerdict();
		end
	end
endmodule // mem_ref_address_and_store_test
`default_nettype wire
